// [common/clk_rst_pkg.sv]
// constants and types for clock selection, start-up reset and clock gating
package clk_rst_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_SLEEP  = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_FUSES  = 4'h8;

  // status fields
  localparam int STAT_RESET_BIT    = 0;
  localparam int STAT_SLEEP_BIT    = 1;
  localparam int STAT_WAKE_BIT     = 2;
  localparam int STAT_RESERVED_BIT = 3;
  localparam int STAT_SRC_LSB      = 4;

  // fuse readback fields
  localparam int FUSE_CLOCK_SOURCE_SELECT_FUSES_LSB = 0;
  localparam int FUSE_SUT_LSB   = 4;
  localparam int FUSE_DIV_BIT   = 6;

  // ****************************************
  // fuse codes and shipped defaults
  // ****************************************
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RESERVED = 4'h1;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_DEFAULT  = 4'h2;
  localparam logic [1:0] SUT_DEFAULT    = 2'h2;
  localparam logic       DIV8_DEFAULT   = 1'b0;
  localparam logic       FUSE_PROGRAMMED = 1'b0;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] STARTUP_EXT    = 16'h0006;
  localparam logic [15:0] STARTUP_258    = 16'h0102;
  localparam logic [15:0] STARTUP_1K     = 16'h0400;
  localparam logic [15:0] STARTUP_16K    = 16'h4000;
  localparam logic [15:0] STARTUP_32K    = 16'h8000;
  localparam logic [15:0] TIMEOUT_4K     = 16'h1000;
  localparam logic [15:0] TIMEOUT_8K     = 16'h2000;
  localparam logic [2:0]  DIV8_LAST      = 3'h7;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SRC_LP_XTAL, SRC_FS_XTAL, SRC_LF_XTAL, SRC_RC128, SRC_RC_CAL, SRC_EXT
  } source_t;

  typedef enum logic [2:0] {
    SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR, SLP_PWR_DOWN, SLP_PWR_SAVE, SLP_STANDBY
  } sleep_mode_t;

  localparam logic [2:0] SLP_LAST_CODE = 3'h5;

  // source decode of the four select fuses; reserved code falls back to RC
  function automatic source_t decodeSource(input logic [3:0] ck);
    if (ck[3])
      return SRC_LP_XTAL;
    else if (ck[2:1] == 2'h3)
      return SRC_FS_XTAL;
    else if (ck[2:1] == 2'h2)
      return SRC_LF_XTAL;
    else if (ck == 4'h3)
      return SRC_RC128;
    else if (ck == 4'h0)
      return SRC_EXT;
    else
      return SRC_RC_CAL;
  endfunction : decodeSource

endpackage : clk_rst_pkg

// [design/clock_select_startup_reset.sv]
// clock source selection, start-up reset sequencing and clock gating
// Function
// R1: four select fuses choose the clock source
// R2: fuse one is unprogrammed, zero programmed
// R3: default RC 8 MHz divided by eight
// R4: extra supply time-out after reset sources release
// R5: time-out counted in watchdog oscillator cycles
// R6: time-out lengths zero, 4096 or 8192
// R7: time-out never senses supply level
// R8: brown-out enable holds reset until supply good
// R9: ripple count of oscillator cycles releases reset
// R10: start-up count six to 32K by type
// R11: reset start applies time-out then start-up
// R12: deep-sleep wake applies only start-up count
// R13: gate unused clocks by sleep mode
// R14: core clock stops all core operation
// R15: peripheral clock drives timers, serial, interrupts
// R16: program memory clock follows core clock
// R17: async timer clocked separately, runs in sleep (code stops it in power-down and standby sleep and during internal reset)
// R18: converter clock runs in noise reduction
// R19: low-power crystal range from upper bits
// R20: fuses sampled only during reset
`timescale 1ns/1ps
module clock_select_startup_reset
  import clk_rst_pkg::*;
#(
  parameter logic [15:0] TIMEOUT_LONG = clk_rst_pkg::TIMEOUT_8K,
  parameter logic [15:0] START_16K    = clk_rst_pkg::STARTUP_16K,
  parameter logic [15:0] START_32K    = clk_rst_pkg::STARTUP_32K
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [3:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdData,
  // fuses and reset sources
  input  wire logic [3:0]           clockSourceSelectFuses,
  input  wire logic [1:0]           startupTimeFuses,
  input  wire logic                 divideByEightFuse,
  input  wire logic                 brownoutDetectorEnable,
  input  wire logic                 supplyOk,
  input  wire logic                 extResetReq,
  input  wire logic                 wakeEvent,
  // oscillator levels
  input  wire logic                 lpXtalOsc,
  input  wire logic                 fsXtalOsc,
  input  wire logic                 lfXtalOsc,
  input  wire logic                 rc128Osc,
  input  wire logic                 rcCalOsc,
  input  wire logic                 extClkIn,
  input  wire logic                 watchdogOsc,
  input  wire logic                 asyncTimerOsc,
  // reset and clock enables
  output logic                      internalReset,
  output logic                      coreClockEn,
  output logic                      peripheralClockEn,
  output logic                      programMemoryClockEn,
  output logic                      asyncTimerClockEn,
  output logic                      converterClockEn,
  // selection state
  output clk_rst_pkg::source_t      activeSource,
  output logic      [1:0]           lpCrystalRange
);
  import clk_rst_pkg::*;

  typedef enum logic [2:0] {
    ST_HOLD, ST_TIMEOUT, ST_STABLE, ST_RUN, ST_SLEEP, ST_WAKE
  } state_t;

  state_t      state;
  sleep_mode_t sleepMode;
  logic [18:0] asyncIn;
  logic [18:0] syncA;
  logic [18:0] syncB;
  logic [7:0]  oscPrev;
  logic [7:0]  oscEdge;
  logic [3:0]  ckselLatch;
  logic [1:0]  sutLatch;
  logic        divLatch;
  logic        reservedSeen;
  logic [2:0]  divCnt;
  logic        selEdge;
  logic        sysTick;
  logic        resetReq;
  logic        timeoutDone;
  logic        stableDone;
  logic        wakePrev;
  logic        wakeRise;
  logic        running;
  logic        sleeping;
  logic [15:0] timeoutTarget;
  logic [15:0] stableTarget;

  // ****************************************
  // input synchronisers
  // ****************************************
  assign asyncIn = {clockSourceSelectFuses, startupTimeFuses, divideByEightFuse,
                    brownoutDetectorEnable, supplyOk, extResetReq, wakeEvent,
                    asyncTimerOsc, watchdogOsc, extClkIn, rcCalOsc, rc128Osc,
                    lfXtalOsc, fsXtalOsc, lpXtalOsc};

  // no reset here: fuse pins must already sit in the
  // second stage when reset releases, for the fuse latch
  always_ff @(posedge core_clk) begin
    syncA <= asyncIn;
    syncB <= syncA;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      oscPrev  <= '0;
      wakePrev <= 1'b0;
    end else begin
      oscPrev  <= syncB[7:0];
      wakePrev <= syncB[8];
    end
  end

  assign oscEdge  = syncB[7:0] & ~oscPrev;
  assign wakeRise = syncB[8] & ~wakePrev;
  assign resetReq = rst || syncB[9] || (syncB[11] && !syncB[10]); // R4 R8

  // ****************************************
  // fuse latch
  // ****************************************
  // fuses follow the pins only while held in reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ckselLatch <= CLOCK_SOURCE_SELECT_FUSES_DEFAULT; // R3
      sutLatch   <= SUT_DEFAULT;
      divLatch   <= DIV8_DEFAULT;
    end else if (state == ST_HOLD) begin // R20
      ckselLatch <= syncB[18:15];
      sutLatch   <= syncB[14:13];
      divLatch   <= syncB[12];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      activeSource   <= SRC_RC_CAL;
      lpCrystalRange <= 2'h0;
      reservedSeen   <= 1'b0;
    end else begin
      activeSource   <= decodeSource(ckselLatch); // R1
      lpCrystalRange <= ckselLatch[3] ? ckselLatch[2:1] : 2'h0; // R19
      reservedSeen   <= (ckselLatch == CLOCK_SOURCE_SELECT_FUSES_RESERVED);
    end
  end

  // ****************************************
  // count selection
  // ****************************************
  function automatic logic [15:0] supplyTimeout(input source_t s, input logic [3:0] ck,
                                                 input logic [1:0] startup_time_fuses);
    logic [2:0] key;
    key = {ck[0], startup_time_fuses};
    if (s == SRC_LP_XTAL || s == SRC_FS_XTAL) begin
      unique case (key)
        3'h2, 3'h5: return CNT_ZERO;
        3'h1, 3'h4, 3'h7: return TIMEOUT_LONG;
        default: return TIMEOUT_4K;
      endcase
    end else begin
      unique case (startup_time_fuses)
        2'h0: return CNT_ZERO;
        2'h1: return TIMEOUT_4K;
        default: return TIMEOUT_LONG;
      endcase
    end
  endfunction : supplyTimeout

  function automatic logic [15:0] startupCount(input source_t s, input logic [3:0] ck,
                                                input logic [1:0] startup_time_fuses);
    logic [2:0] key;
    key = {ck[0], startup_time_fuses};
    if (s == SRC_LP_XTAL || s == SRC_FS_XTAL) begin
      unique case (key)
        3'h0, 3'h1: return STARTUP_258;
        3'h2, 3'h3, 3'h4: return STARTUP_1K;
        default: return START_16K;
      endcase
    end else if (s == SRC_LF_XTAL) begin
      return START_32K;
    end else begin
      return STARTUP_EXT;
    end
  endfunction : startupCount

  // decoded from the latch itself: activeSource lags it by a cycle
  assign timeoutTarget = supplyTimeout(decodeSource(ckselLatch), ckselLatch, sutLatch); // R5 R6
  assign stableTarget  = startupCount(decodeSource(ckselLatch), ckselLatch, sutLatch); // R10

  // ****************************************
  // start-up counters
  // ****************************************
  startup_counter #(
    .WIDTH (16)
  ) timeoutCounter (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (state == ST_TIMEOUT),
    .tick     (oscEdge[6]), // R5 R7
    .target   (timeoutTarget),
    .done     (timeoutDone)
  );

  startup_counter #(
    .WIDTH (16)
  ) stableCounter (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (state == ST_STABLE || state == ST_WAKE),
    .tick     (selEdge), // R9
    .target   (stableTarget),
    .done     (stableDone)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (resetReq) begin
      state <= ST_HOLD; // R4 R8
    end else begin
      unique case (state)
        ST_HOLD: state <= ST_TIMEOUT; // R11
        ST_TIMEOUT: if (timeoutDone) state <= ST_STABLE;
        ST_STABLE: if (stableDone) state <= ST_RUN; // R9
        ST_RUN: if (sleepMode != SLP_ACTIVE) state <= ST_SLEEP;
        ST_SLEEP: begin
          if (wakeRise) begin
            if (sleepMode == SLP_PWR_DOWN || sleepMode == SLP_PWR_SAVE)
              state <= ST_WAKE; // R12
            else
              state <= ST_RUN;
          end
        end
        ST_WAKE: if (stableDone) state <= ST_RUN;
      endcase
    end
  end

  // ****************************************
  // register port
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleepMode <= SLP_ACTIVE;
    end else if (internalReset || (state == ST_SLEEP && wakeRise)) begin
      sleepMode <= SLP_ACTIVE;
    end else if (regWrite && regAddr == ADDR_SLEEP && state == ST_RUN
                 && regWrData[2:0] <= SLP_LAST_CODE) begin
      sleepMode <= sleep_mode_t'(regWrData[2:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !regRead) begin
      regRdData <= 8'h00;
    end else begin
      unique case (regAddr)
        ADDR_SLEEP: regRdData <= {5'h00, sleepMode};
        ADDR_STATUS: begin
          regRdData                     <= 8'h00;
          regRdData[STAT_RESET_BIT]     <= internalReset;
          regRdData[STAT_SLEEP_BIT]     <= sleeping;
          regRdData[STAT_WAKE_BIT]      <= (state == ST_WAKE);
          regRdData[STAT_RESERVED_BIT]  <= reservedSeen;
          regRdData[STAT_SRC_LSB +: 3]  <= activeSource;
        end
        ADDR_FUSES: begin
          regRdData                     <= 8'h00;
          regRdData[FUSE_CLOCK_SOURCE_SELECT_FUSES_LSB +: 4] <= ckselLatch;
          regRdData[FUSE_SUT_LSB +: 2]   <= sutLatch;
          regRdData[FUSE_DIV_BIT]        <= divLatch;
        end
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // system clock divider
  // ****************************************
  assign selEdge = oscEdge[activeSource];

  always_ff @(posedge core_clk) begin
    if (rst || internalReset)
      divCnt <= 3'h0;
    else if (selEdge)
      divCnt <= divCnt + 1'b1;
  end

  // a stored zero means programmed: divide by eight
  assign sysTick = selEdge && (divLatch != FUSE_PROGRAMMED || divCnt == DIV8_LAST); // R2 R3

  // ****************************************
  // clock gating
  // ****************************************
  assign internalReset = (state == ST_HOLD || state == ST_TIMEOUT
                          || state == ST_STABLE); // R11
  assign running  = (state == ST_RUN);
  assign sleeping = (state == ST_SLEEP);

  assign coreClockEn          = sysTick && running; // R13 R14
  assign programMemoryClockEn = coreClockEn; // R16
  assign peripheralClockEn    = sysTick && (running || (sleeping && sleepMode == SLP_IDLE)); // R15
  assign converterClockEn     = sysTick && (running || (sleeping
                                && (sleepMode == SLP_IDLE || sleepMode == SLP_ADC_NR))); // R18
  assign asyncTimerClockEn    = oscEdge[7] && !internalReset && !(sleeping
                                && (sleepMode == SLP_PWR_DOWN || sleepMode == SLP_STANDBY)); // R17

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_RESET_SOURCE: assert property (syncB[9] |=> internalReset) // R4
    else $error("reset source did not hold internal reset");

  AST_BOD_HOLD: assert property (syncB[11] && !syncB[10] |=> state == ST_HOLD) // R8
    else $error("brown-out did not hold reset");

  AST_TIMEOUT_FIRST: assert property (state == ST_HOLD && !resetReq |=> state == ST_TIMEOUT) // R11
    else $error("time-out not applied after reset");

  AST_RELEASE: assert property (state == ST_STABLE && stableDone && !resetReq
                                |=> running && !internalReset) // R9
    else $error("reset not released after start-up count");

  AST_WAKE_SKIP: assert property (sleeping && wakeRise && !resetReq
                                  && sleepMode == SLP_PWR_DOWN |=> state == ST_WAKE) // R12
    else $error("deep wake skipped the start-up count");

  AST_CORE_HALT: assert property (internalReset || sleeping |-> !coreClockEn) // R13 R14
    else $error("core clock ran while halted");

  AST_FLASH_FOLLOW: assert property (coreClockEn |-> programMemoryClockEn) // R16
    else $error("program memory clock not with core clock");

  AST_NOISE_RED: assert property (sleeping && sleepMode == SLP_ADC_NR && sysTick
                                  |-> converterClockEn && !peripheralClockEn) // R15 R18
    else $error("noise reduction gating wrong");

  AST_ASYNC_SLEEP: assert property (sleeping && sleepMode == SLP_PWR_SAVE && oscEdge[7]
                                    |-> asyncTimerClockEn) // R17
    else $error("async timer stopped in power-save");

  AST_FUSE_HOLD: assert property (running && $past(running) |-> $stable(ckselLatch)) // R20
    else $error("fuses changed during operation");

  AST_DIV8: assert property (divLatch == FUSE_PROGRAMMED && sysTick |=> !sysTick [*7]) // R3
    else $error("divide by eight tick spacing wrong");

endmodule : clock_select_startup_reset

// [design/startup_counter.sv]
// cycle counter for supply time-out and oscillator start-up
`timescale 1ns/1ps
module startup_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] target,
  // result
  output logic                  done
);

  logic [WIDTH-1:0] count;

  // ****************************************
  // counting
  // ****************************************
  // cleared whenever not running; counts only ticks, no level sensing
  always_ff @(posedge core_clk) begin
    if (rst || !run)
      count <= '0;
    else if (tick && count != target)
      count <= count + 1'b1;
  end

  assign done = run && (count == target);

endmodule : startup_counter

// [verif/clock_select_startup_reset_tb.sv]
// self-checking bench for clock selection, start-up reset and gating
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin numErrors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module clock_select_startup_reset_tb;
  import clk_rst_pkg::*;
  typedef struct {logic [3:0] ck; logic [1:0] startup_time_fuses; int n; source_t src;} case_t;
  logic core_clk, rst, regWrite, regRead, divideByEightFuse, brownoutDetectorEnable;
  logic supplyOk, extResetReq, wakeEvent, internalReset, coreClockEn, peripheralClockEn;
  logic programMemoryClockEn, asyncTimerClockEn, converterClockEn;
  logic lpXtalOsc, fsXtalOsc, lfXtalOsc, rc128Osc, rcCalOsc, extClkIn, watchdogOsc;
  logic asyncTimerOsc;
  logic [3:0] regAddr, clockSourceSelectFuses;
  logic [7:0] regWrData, regRdData, rdv;
  logic [1:0] startupTimeFuses, lpCrystalRange;
  logic [4:0] en, got;
  source_t    activeSource;
  int numErrors, numChecks, cyc, cnt[5];
  logic [4:0] smask[6] = '{5'h1F, 5'h0B, 5'h03, 5'h00, 5'h02, 5'h00};
  case_t tbl[7] = '{'{4'h2, 2'h2, 22, SRC_RC_CAL}, '{4'h0, 2'h0, 6, SRC_EXT},
    '{4'h3, 2'h1, 4102, SRC_RC128}, '{4'hF, 2'h3, 48, SRC_LP_XTAL},
    '{4'h7, 2'h1, 32, SRC_FS_XTAL}, '{4'h1, 2'h0, 6, SRC_RC_CAL},
    '{4'h8, 2'h2, 1024, SRC_LP_XTAL}};
  assign en = {coreClockEn, peripheralClockEn, programMemoryClockEn, asyncTimerClockEn,
               converterClockEn};

  clock_select_startup_reset #(.TIMEOUT_LONG(16'h0010), .START_16K(16'h0020),
    .START_32K(16'h0040)) i_clock_select_startup_reset (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .clockSourceSelectFuses(clockSourceSelectFuses), .startupTimeFuses(startupTimeFuses),
    .divideByEightFuse(divideByEightFuse), .brownoutDetectorEnable(brownoutDetectorEnable),
    .supplyOk(supplyOk), .extResetReq(extResetReq), .wakeEvent(wakeEvent),
    .lpXtalOsc(lpXtalOsc), .fsXtalOsc(fsXtalOsc), .lfXtalOsc(lfXtalOsc),
    .rc128Osc(rc128Osc), .rcCalOsc(rcCalOsc), .extClkIn(extClkIn),
    .watchdogOsc(watchdogOsc), .asyncTimerOsc(asyncTimerOsc),
    .internalReset(internalReset), .coreClockEn(coreClockEn),
    .peripheralClockEn(peripheralClockEn), .programMemoryClockEn(programMemoryClockEn),
    .asyncTimerClockEn(asyncTimerClockEn), .converterClockEn(converterClockEn),
    .activeSource(activeSource), .lpCrystalRange(lpCrystalRange));

  osc_model i_osc_model (
    .core_clk(core_clk), .lpXtalOsc(lpXtalOsc), .fsXtalOsc(fsXtalOsc),
    .lfXtalOsc(lfXtalOsc), .rc128Osc(rc128Osc), .rcCalOsc(rcCalOsc), .extClkIn(extClkIn),
    .watchdogOsc(watchdogOsc), .asyncTimerOsc(asyncTimerOsc));

  // ****************************************
  // bus and sequencing tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 rdv = regRdData;
    @(posedge core_clk);
  endtask : rd

  task automatic boot(input logic [3:0] ck, input logic [1:0] startup_time_fuses, input logic dv);
    clockSourceSelectFuses <= ck;
    startupTimeFuses <= startup_time_fuses;
    divideByEightFuse <= dv;
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
  endtask : boot

  task automatic waitRelease();
    cyc = 0;
    do begin
      @(posedge core_clk);
      #1 cyc++;
    end while (internalReset !== 1'b0 && cyc < 20000);
  endtask : waitRelease

  task automatic count(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge core_clk);
      #1;
      for (int k = 0; k < 5; k++) if (en[k] === 1'b1) cnt[k]++;
    end
    for (int k = 0; k < 5; k++) got[k] = (cnt[k] > 0);
  endtask : count

  task automatic reportAndStop();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : reportAndStop

  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    #(100 * 60000);
    numErrors++;
    reportAndStop();
  end

  initial begin
    {rst, regWrite, regRead, extResetReq, wakeEvent, brownoutDetectorEnable} = 6'h20;
    {supplyOk, regAddr, regWrData} = {1'b1, 4'h0, 8'h00};
    {clockSourceSelectFuses, startupTimeFuses, divideByEightFuse} = 7'h14;
    // release timing and source per fuse setting
    foreach (tbl[i]) begin
      boot(tbl[i].ck, tbl[i].startup_time_fuses, 1'b1);
      waitRelease();
      `CHK("release", 1'b1, cyc >= 4 * tbl[i].n - 8 && cyc <= 4 * tbl[i].n + 16)
      `CHK("source", tbl[i].src, activeSource)
      rd(ADDR_STATUS);
      `CHK("reserved", tbl[i].ck == 4'h1, rdv[STAT_RESERVED_BIT])
    end
    `CHK("lp range", 2'h0, lpCrystalRange)
    boot(4'hF, 2'h3, 1'b1);
    waitRelease();
    `CHK("lp range", 2'h3, lpCrystalRange)
    // shipped defaults, divided system tick, read-only fuses
    boot(CLOCK_SOURCE_SELECT_FUSES_DEFAULT, SUT_DEFAULT, DIV8_DEFAULT);
    waitRelease();
    count(320);
    `CHK("div8 ticks", 1'b1, cnt[4] >= 9 && cnt[4] <= 11)
    `CHK("flash follows", cnt[4], cnt[2])
    clockSourceSelectFuses <= 4'h0;
    wr(ADDR_FUSES, 8'hFF);
    rd(ADDR_FUSES);
    `CHK("fuses", 8'h22, rdv)
    rd(ADDR_STATUS);
    `CHK("status", 8'h40, rdv)
    rd(4'hC);
    `CHK("unmapped", 8'h00, rdv)
    wr(ADDR_SLEEP, 8'h07);
    rd(ADDR_SLEEP);
    `CHK("bad mode", 8'h00, rdv)
    boot(CLOCK_SOURCE_SELECT_FUSES_DEFAULT, SUT_DEFAULT, 1'b1);
    waitRelease();
    count(320);
    `CHK("undivided", 1'b1, cnt[4] >= 79 && cnt[4] <= 81)
    // gating per sleep mode and wake timing
    for (int m = 0; m < 6; m++) begin
      if (m > 0) wr(ADDR_SLEEP, 8'(m));
      count(40);
      `CHK("gating", smask[m], got)
      if (m > 0) begin
        rd(ADDR_SLEEP);
        `CHK("mode", 8'(m), rdv)
        wakeEvent <= 1'b1;
        repeat (3) @(posedge core_clk);
        wakeEvent <= 1'b0;
        cyc = 0;
        got[0] = 1'b0;
        while (coreClockEn !== 1'b1 && cyc < 200) begin
          @(posedge core_clk);
          #1 cyc++;
          if (internalReset !== 1'b0) got[0] = 1'b1;
        end
        `CHK("wake time", 1'b1, cyc <= 40)
        `CHK("wake no reset", 1'b0, got[0])
      end
    end
    supplyOk <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK("no level sense", 1'b0, internalReset)
    // brown-out hold, supply loss and external reset in run
    brownoutDetectorEnable <= 1'b1;
    supplyOk <= 1'b0;
    boot(CLOCK_SOURCE_SELECT_FUSES_DEFAULT, SUT_DEFAULT, 1'b1);
    repeat (200) @(posedge core_clk);
    `CHK("bod hold", 1'b1, internalReset)
    supplyOk <= 1'b1;
    waitRelease();
    `CHK("bod release", 1'b1, cyc >= 80 && cyc <= 110)
    supplyOk <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK("bod in run", 1'b1, internalReset)
    supplyOk <= 1'b1;
    waitRelease();
    extResetReq <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK("ext reset", 1'b1, internalReset)
    extResetReq <= 1'b0;
    waitRelease();
    `CHK("timeout again", 1'b1, cyc >= 80 && cyc <= 110)
    reportAndStop();
  end
endmodule : clock_select_startup_reset_tb

// [verif/osc_model.sv]
// oscillator, watchdog and async crystal sources seen by the clock block
`timescale 1ns/1ps
module osc_model (
  // clock
  input  wire logic core_clk,
  // oscillator levels
  output logic      lpXtalOsc,
  output logic      fsXtalOsc,
  output logic      lfXtalOsc,
  output logic      rc128Osc,
  output logic      rcCalOsc,
  output logic      extClkIn,
  output logic      watchdogOsc,
  output logic      asyncTimerOsc
);
  // ****************************************
  // free-running sources, each level held two cycles, async crystal level held four
  // ****************************************
  logic [2:0] phase = 3'h0;
  always_ff @(posedge core_clk) begin
    phase <= phase + 3'h1;
  end
  assign lpXtalOsc     = phase[1];
  assign fsXtalOsc     = phase[1];
  assign lfXtalOsc     = phase[1];
  assign rc128Osc      = phase[1];
  assign rcCalOsc      = phase[1];
  assign extClkIn      = phase[1];
  assign watchdogOsc   = ~phase[1];
  assign asyncTimerOsc = phase[2];
endmodule : osc_model
